// file: rtl/tnau_defines.svh
`ifndef TNAU_DEFINES_SVH
`define TNAU_DEFINES_SVH
// APB register map
`define TNAU_OFF_STATUS 12'h000
`define TNAU_OFF_CTRL 12'h004
`define TNAU_OFF_STATE 12'h008
// Status word fields
`define TNAU_ST_EXPLICIT 0
`define TNAU_ST_RETRY 1
`define TNAU_ST_CONFLICT 2
`define TNAU_ST_OVERFLOW 3
`define TNAU_ST_DEBUG 4
`define TNAU_ST_NESTED 5
`define TNAU_ST_ARG_LO 24
`define TNAU_ST_ARG_HI 31
// Debug enable bit positions
`define TNAU_DR_ADV_BIT 11
`define TNAU_MSR_ADV_BIT 15
`define TNAU_DSR_RTM_BIT 16
// Limits
`define TNAU_HINT_NEST_LIMIT 4'h8
`define TNAU_RSTR_NEST_LIMIT 4'h7
`define TNAU_LOCK_CAP 2
`define TNAU_CNT_W 4
`define TNAU_ADDR_W 32
`endif

// file: rtl/tnau_pkg.sv
package tnau_pkg;
  // Pipeline event bundle
  typedef struct packed {
    logic acq;
    logic rel;
    logic [31:0] lock_addr;
    logic begin_op;
    logic [31:0] fallback;
    logic end_op;
    logic abort_op;
    logic [7:0] abort_imm;
    logic conflict;
    logic overflow;
    logic dbg_exc;
    logic other_abort;
    logic retry_hint;
  } tnau_evt_type;
  // Outcome bundle to state and commit logic
  typedef struct packed {
    logic enter;
    logic commit;
    logic abort;
    logic restore_begin;
    logic redirect;
    logic [31:0] target;
    logic replay_unhinted;
    logic deliver_dbg;
    logic clr_dsr16;
    logic discard;
  } tnau_out_type;
  typedef enum logic [2:0] {
    TNAU_IDLE = 3'b001,
    TNAU_HINT = 3'b010,
    TNAU_RSTR = 3'b100
  } tnau_state_type;
endpackage

// file: rtl/tnau_core.sv
// What this block does
// - Abort restores to outermost region start
// - Hidden hinted nest counter up/down
// - Enter transaction on hinted 0-to-1
// - Hinted commit only at counter zero
// - Abort above hinted nest limit
// - Track elided locks up to capacity
// - Full tracker: write-set, keep transacting
// - Freed slot lets next lock elide
// - Commit needs all pairs matched, zero
// - Failed hinted region replays unhinted
// - Restricted counter; commit at zero
// - Abort above restricted nest limit
// - Ignore hints inside restricted; abort mixed
// - Explicit abort: bit0, argument in 31:24
// - Retry bit never set with bit0
// - Cause bits 2,3,4,5
// - Bits 23:6 reserved; zero status allowed
// - Commit atomic, ordered like locked op
// - Begin no fence; abort discards updates
// - Default debug abort redirects, bit4
// - Advanced debug rolls back, clears 16
// - Restricted abort resumes at fallback
// - Abort immediate loaded into status
`timescale 1ns/1ps
`default_nettype none
`include "tnau_defines.svh"
module tnau_core (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire tnau_pkg::tnau_evt_type evt, // Pipeline events
  input wire logic lock_ok, // Lock requirements met
  input wire logic [31:0] debug_control_reg, // Debug control
  input wire logic [31:0] debug_ctl_msr, // Debug control MSR
  output tnau_pkg::tnau_out_type res, // Outcome, registered
  output logic txn_active // Transactional execution
);
  import tnau_pkg::*;

  // ---------------------------------------------
  // Architectural state
  // ---------------------------------------------
  tnau_state_type st_r, st_nxt;
  logic [`TNAU_CNT_W-1:0] hcnt_r, hcnt_nxt;
  logic [`TNAU_CNT_W-1:0] rcnt_r, rcnt_nxt;
  logic [`TNAU_LOCK_CAP-1:0] slot_v_r, slot_v_nxt;
  logic [`TNAU_ADDR_W-1:0] slot_a_r [`TNAU_LOCK_CAP];
  logic [31:0] status_r, status_nxt;
  logic [31:0] saved_r;
  logic [31:0] fb_r;
  logic nohint_r, nohint_nxt;
  logic wset_r;
  tnau_out_type res_nxt;

  // Slot lookup used by acquire
  function automatic logic [`TNAU_LOCK_CAP:0] find_slot(
    input logic [`TNAU_LOCK_CAP-1:0] v, input logic want);
    logic [`TNAU_LOCK_CAP:0] r;
    r = '0;
    for (int i = 0; i < `TNAU_LOCK_CAP; i++) begin
      if (v[i] == want && !r[`TNAU_LOCK_CAP]) begin
        r = {1'b1, `TNAU_LOCK_CAP'(1) << i};
      end
    end
    return r;
  endfunction

  // ---------------------------------------------
  // Event decode
  // ---------------------------------------------
  wire in_rstr = (st_r == TNAU_RSTR);
  wire in_hint = (st_r == TNAU_HINT);
  // Hints inside restricted regions are ignored; hints after replay too
  wire hint_live = !in_rstr && !nohint_r;
  wire acq_v = evt.acq && hint_live;
  wire rel_v = evt.rel && in_hint;
  wire [`TNAU_LOCK_CAP:0] free_s = find_slot(slot_v_r, 1'b0);
  logic [`TNAU_LOCK_CAP-1:0] match_s;
  always_comb begin
    match_s = '0;
    for (int i = 0; i < `TNAU_LOCK_CAP; i++) begin
      match_s[i] = slot_v_r[i] && (slot_a_r[i] == evt.lock_addr);
    end
  end
  wire hint_over = acq_v && (hcnt_r == `TNAU_HINT_NEST_LIMIT);
  wire rstr_over = evt.begin_op && (rcnt_r == `TNAU_RSTR_NEST_LIMIT);
  // Restricted ops in a hinted region abort; replay drops elision
  wire mixed_ab = in_hint && (evt.begin_op || evt.end_op || evt.abort_op);
  wire ext_ab = (st_r != TNAU_IDLE) && (evt.conflict || evt.overflow || evt.dbg_exc
                 || evt.other_abort || (evt.abort_op && in_rstr));
  wire hint_done = in_hint && rel_v && (hcnt_r == `TNAU_CNT_W'(1));
  wire hint_commit = hint_done && lock_ok && !wset_r;
  wire hint_fail = hint_done && !hint_commit;
  wire rstr_commit = in_rstr && evt.end_op && (rcnt_r == `TNAU_CNT_W'(1));
  wire any_ab = ext_ab || hint_over || rstr_over || mixed_ab || hint_fail;
  wire adv_dbg = debug_control_reg[`TNAU_DR_ADV_BIT] && debug_ctl_msr[`TNAU_MSR_ADV_BIT];

  // Status word assembly; reserved bits stay zero
  function automatic logic [31:0] mk_status(input tnau_evt_type e, input logic nested);
    logic [31:0] s;
    s = '0;
    s[`TNAU_ST_EXPLICIT] = e.abort_op;
    s[`TNAU_ST_RETRY] = e.retry_hint && !e.abort_op;
    s[`TNAU_ST_CONFLICT] = e.conflict;
    s[`TNAU_ST_OVERFLOW] = e.overflow;
    s[`TNAU_ST_DEBUG] = e.dbg_exc;
    s[`TNAU_ST_NESTED] = nested;
    if (e.abort_op) begin
      s[`TNAU_ST_ARG_HI:`TNAU_ST_ARG_LO] = e.abort_imm;
    end
    return s;
  endfunction

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------
  always_comb begin
    st_nxt = st_r;
    hcnt_nxt = hcnt_r;
    rcnt_nxt = rcnt_r;
    slot_v_nxt = slot_v_r;
    status_nxt = status_r;
    nohint_nxt = nohint_r;
    res_nxt = '0;
    if (any_ab) begin
      // One monolithic region: always back to outermost start
      st_nxt = TNAU_IDLE;
      hcnt_nxt = '0;
      rcnt_nxt = '0;
      slot_v_nxt = '0;
      res_nxt.abort = 1'b1;
      res_nxt.discard = 1'b1;
      res_nxt.restore_begin = 1'b1;
      if (in_hint) begin
        nohint_nxt = 1'b1;
        res_nxt.replay_unhinted = 1'b1;
      end else if (in_rstr && evt.dbg_exc && adv_dbg) begin
        status_nxt = saved_r;
        res_nxt.deliver_dbg = 1'b1;
        res_nxt.clr_dsr16 = 1'b1;
      end else begin
        status_nxt = mk_status(evt, rcnt_r > `TNAU_CNT_W'(1));
        res_nxt.redirect = 1'b1;
        res_nxt.target = fb_r;
      end
    end else if (in_rstr) begin
      if (evt.begin_op) begin
        rcnt_nxt = rcnt_r + `TNAU_CNT_W'(1);
      end else if (evt.end_op) begin
        rcnt_nxt = rcnt_r - `TNAU_CNT_W'(1);
        if (rstr_commit) begin
          st_nxt = TNAU_IDLE;
          res_nxt.commit = 1'b1;
          slot_v_nxt = '0;
        end
      end
    end else if (evt.begin_op && st_r == TNAU_IDLE) begin
      st_nxt = TNAU_RSTR;
      rcnt_nxt = `TNAU_CNT_W'(1);
      res_nxt.enter = 1'b1;
    end else if (acq_v) begin
      hcnt_nxt = hcnt_r + `TNAU_CNT_W'(1);
      if (hcnt_r == '0) begin
        st_nxt = TNAU_HINT;
        res_nxt.enter = 1'b1;
      end
      if (free_s[`TNAU_LOCK_CAP]) begin
        slot_v_nxt = slot_v_r | free_s[`TNAU_LOCK_CAP-1:0];
      end
    end else if (rel_v) begin
      hcnt_nxt = hcnt_r - `TNAU_CNT_W'(1);
      slot_v_nxt = slot_v_r & ~match_s;
      if (hint_commit) begin
        st_nxt = TNAU_IDLE;
        res_nxt.commit = 1'b1;
        slot_v_nxt = '0;
      end
    end
    // Replay window ends when the next release retires
    if (nohint_r && evt.rel && !any_ab) begin
      nohint_nxt = 1'b0;
    end
    res_nxt.discard = res_nxt.abort;
  end

  // ---------------------------------------------
  // APB slave, no wait states
  // ---------------------------------------------
  wire acc = psel && penable;
  wire hit_st = (paddr == `TNAU_OFF_STATUS);
  wire hit_ct = (paddr == `TNAU_OFF_CTRL);
  wire hit_sn = (paddr == `TNAU_OFF_STATE);
  wire unmapped = !(hit_st || hit_ct || hit_sn);
  wire [31:0] rd_mux = hit_st ? status_r :
                       hit_sn ? {20'h00000, rcnt_r, hcnt_r, 1'b0, st_r} :
                       hit_ct ? {31'h00000000, nohint_r} : 32'h00000000;
  logic [31:0] prdata_nxt;
  // Latched at setup so the word stands on the edge that samples pready
  assign prdata_nxt = (psel && !penable && !pwrite) ? rd_mux : prdata;

  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= TNAU_IDLE;
      hcnt_r <= '0;
      rcnt_r <= '0;
      slot_v_r <= '0;
      status_r <= '0;
      nohint_r <= 1'b0;
      res <= '0;
      txn_active <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      st_r <= st_nxt;
      hcnt_r <= hcnt_nxt;
      rcnt_r <= rcnt_nxt;
      slot_v_r <= slot_v_nxt;
      // Hardware update wins over a software write in the same cycle
      if (res_nxt.abort) begin
        status_r <= status_nxt;
      end else if (acc && pwrite && hit_st && pready) begin
        status_r <= pwdata;
      end
      // Hardware replay request wins over a same-cycle software clear
      if (res_nxt.replay_unhinted) begin
        nohint_r <= 1'b1;
      end else if (acc && pwrite && hit_ct && pready) begin
        nohint_r <= pwdata[0];
      end else begin
        nohint_r <= nohint_nxt;
      end
      res <= res_nxt;
      txn_active <= (st_nxt != TNAU_IDLE);
      prdata <= prdata_nxt;
      pready <= psel && !pready;
      pslverr <= psel && !pready && unmapped;
    end
  end

  // Slot addresses, write-set flag and begin snapshots
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `TNAU_LOCK_CAP; i++) begin
        slot_a_r[i] <= '0;
      end
      wset_r <= 1'b0;
      saved_r <= '0;
      fb_r <= '0;
    end else begin
      for (int i = 0; i < `TNAU_LOCK_CAP; i++) begin
        if (acq_v && !any_ab && free_s[i] && free_s[`TNAU_LOCK_CAP]) begin
          slot_a_r[i] <= evt.lock_addr;
        end
      end
      // No slot left: lock goes into the write-set, still transactional
      if (st_nxt == TNAU_IDLE) begin
        wset_r <= 1'b0;
      end else if (acq_v && !free_s[`TNAU_LOCK_CAP]) begin
        wset_r <= 1'b1;
      end
      if (res_nxt.enter && evt.begin_op) begin
        saved_r <= status_r;
        fb_r <= evt.fallback;
      end
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  a_retry_vs_explicit: assert property (@(posedge pclk) disable iff (!presetn)
    !(status_r[`TNAU_ST_EXPLICIT] && status_r[`TNAU_ST_RETRY]))
    else $error("retry and explicit both set");
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    res.abort && !res.deliver_dbg |-> status_r[23:6] == '0)
    else $error("reserved status bits set");
  a_abort_clears: assert property (@(posedge pclk) disable iff (!presetn)
    res.abort |-> hcnt_r == '0 && rcnt_r == '0 && slot_v_r == '0)
    else $error("state left after abort");
  a_hint_enter: assert property (@(posedge pclk) disable iff (!presetn)
    !any_ab && acq_v && hcnt_r == '0 && st_r == TNAU_IDLE |=> res.enter && st_r == TNAU_HINT)
    else $error("no entry on first acquire");
  a_rstr_over: assert property (@(posedge pclk) disable iff (!presetn)
    in_rstr && rstr_over |=> res.abort && st_r == TNAU_IDLE)
    else $error("nest limit not enforced");
  a_explicit_arg: assert property (@(posedge pclk) disable iff (!presetn)
    in_rstr && evt.abort_op && !(evt.dbg_exc && adv_dbg)
    |=> status_r[0] && status_r[31:24] == $past(evt.abort_imm))
    else $error("explicit abort status wrong");
  a_adv_debug: assert property (@(posedge pclk) disable iff (!presetn)
    in_rstr && evt.dbg_exc && adv_dbg |=> res.deliver_dbg && res.clr_dsr16 && !res.redirect)
    else $error("advanced debug path missed");
  a_commit_zero: assert property (@(posedge pclk) disable iff (!presetn)
    res.commit |-> hcnt_r == '0 && rcnt_r == '0)
    else $error("commit with open nesting");
  a_dbg_redirect: assert property (@(posedge pclk) disable iff (!presetn)
    in_rstr && evt.dbg_exc && !adv_dbg |=> res.redirect && status_r[4])
    else $error("default debug abort wrong");

  // ---------------------------------------------
  // Checks on elision, nesting and bus timing
  // ---------------------------------------------
  // Outermost hinted release commits and leaves the region
  a_hint_commit: assert property (@(posedge pclk) disable iff (!presetn)
    hint_commit |=> res.commit && st_r == TNAU_IDLE)
    else $error("hinted commit missed");
  // Full tracker keeps the region alive but marks the write-set
  a_wset_full: assert property (@(posedge pclk) disable iff (!presetn)
    in_hint && acq_v && !any_ab && !free_s[`TNAU_LOCK_CAP] |=> wset_r && st_r == TNAU_HINT)
    else $error("full tracker handling wrong");
  // A free slot is taken by the next acquire
  a_slot_reuse: assert property (@(posedge pclk) disable iff (!presetn)
    acq_v && !any_ab && free_s[`TNAU_LOCK_CAP] |=> (slot_v_r & ~$past(slot_v_r)) != '0)
    else $error("free slot not reused");
  // Failed hinted commit replays without elision
  a_hint_replay: assert property (@(posedge pclk) disable iff (!presetn)
    hint_fail |=> res.abort && res.replay_unhinted && nohint_r)
    else $error("failed hinted region not replayed");
  // Hinted nesting beyond the limit aborts
  a_hint_over: assert property (@(posedge pclk) disable iff (!presetn)
    hint_over |=> res.abort)
    else $error("hinted nest limit not enforced");
  // Restricted region commits when its count returns to zero
  a_rstr_commit: assert property (@(posedge pclk) disable iff (!presetn)
    rstr_commit && !any_ab |=> res.commit && !txn_active)
    else $error("restricted commit missed");
  // Begin from idle opens a restricted region
  a_rstr_enter: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == TNAU_IDLE && evt.begin_op && !any_ab |=> res.enter && st_r == TNAU_RSTR)
    else $error("restricted entry missed");
  // Restricted ops inside a hinted region abort and replay
  a_mixed_abort: assert property (@(posedge pclk) disable iff (!presetn)
    mixed_ab |=> res.abort && res.replay_unhinted)
    else $error("mixed region not aborted");
  // Redirect always goes to the outermost fallback
  a_redirect_target: assert property (@(posedge pclk) disable iff (!presetn)
    res.redirect |-> res.target == fb_r)
    else $error("redirect target wrong");
  // Conflict and overflow causes reach the status word
  a_conflict_bit: assert property (@(posedge pclk) disable iff (!presetn)
    in_rstr && evt.conflict && !evt.dbg_exc |=> status_r[`TNAU_ST_CONFLICT])
    else $error("conflict bit missing");
  a_overflow_bit: assert property (@(posedge pclk) disable iff (!presetn)
    in_rstr && evt.overflow && !evt.dbg_exc |=> status_r[`TNAU_ST_OVERFLOW])
    else $error("overflow bit missing");
  // Abort inside an inner region marks the nested bit
  a_nested_bit: assert property (@(posedge pclk) disable iff (!presetn)
    in_rstr && rcnt_r > `TNAU_CNT_W'(1) && evt.conflict && !evt.dbg_exc
    |=> status_r[`TNAU_ST_NESTED])
    else $error("nested bit missing");
  // Idle means no nesting left over from any region
  a_idle_counts: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == TNAU_IDLE |-> hcnt_r == '0 && rcnt_r == '0)
    else $error("counts left in idle");
  // Commit and abort never in one cycle
  a_outcome_excl: assert property (@(posedge pclk) disable iff (!presetn)
    !(res.commit && res.abort))
    else $error("commit and abort together");
  // Entry always raises the active level
  a_enter_active: assert property (@(posedge pclk) disable iff (!presetn)
    res.enter |-> txn_active)
    else $error("entry without active level");
  // Ready is a single-cycle answer
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");
  // Error only travels with ready
  a_slverr_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");
endmodule
`default_nettype wire

// file: verif/tnau_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
module tnau_pipe_model (
  input wire logic pclk, // Core clock
  output tnau_pkg::tnau_evt_type evt // Decoded instruction events
);
  import tnau_pkg::*;
  // ----------------------------------------
  // Retirement side issue
  // ----------------------------------------
  initial evt = '0;
  // One instruction per edge; the bus drops to idle after it so pulses never merge
  task automatic send(input tnau_evt_type e, input int gap);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    evt <= e;
    @(posedge pclk);
    evt <= '0;
  endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tnau_defines.svh"
module tb_top;
  import tnau_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lock_ok, txn_active, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, dcr, msr, q;
  tnau_evt_type evt;
  tnau_out_type res;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int i;
  tnau_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt(evt), .lock_ok(lock_ok), .debug_control_reg(dcr),
    .debug_ctl_msr(msr), .res(res), .txn_active(txn_active));
  tnau_pipe_model pm (.pclk(pclk), .evt(evt));
  // ----------------------------------------
  // Clock, watchdog, verdict
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Whole run is under 200 cycles; the 4000-cycle ceiling leaves ample slack
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ckb(input string nm, input logic seen, input logic exp);
    chk(nm, {31'h0, seen}, {31'h0, exp});
  endtask
  // ----------------------------------------
  // Bus and event helpers
  // ----------------------------------------
  // Request held until the edge that sees pready; data taken for that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) n_mismatch++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("read data", q, x);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Kinds: 0 acquire, 1 release, 2 begin, 3 end, 4 abort, 5 debug, 6 conflict, 7 overflow
  function automatic tnau_evt_type mk(input int k, input logic [31:0] a);
    tnau_evt_type v;
    v = '0;
    case (k)
      0: begin v.acq = 1'b1; v.lock_addr = a; end
      1: begin v.rel = 1'b1; v.lock_addr = a; end
      2: begin v.begin_op = 1'b1; v.fallback = a; end
      3: v.end_op = 1'b1;
      4: begin v.abort_op = 1'b1; v.abort_imm = a[7:0]; v.retry_hint = 1'b1; end
      5: v.dbg_exc = 1'b1;
      6: v.conflict = 1'b1;
      default: v.overflow = 1'b1;
    endcase
    return v;
  endfunction
  // Outcome lands on the edge after the event, so look just past it
  task automatic ev(input int k, input logic [31:0] a);
    pm.send(mk(k, a), 0);
    #1;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lock_ok = 1'b1;
    dcr = 32'h0;
    msr = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TNAU_OFF_STATUS, 32'h0);
    rd(`TNAU_OFF_STATE, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    ckb("slverr", e, 1'b1);
    wr(`TNAU_OFF_STATE, 32'hFFFF);
    rd(`TNAU_OFF_STATE, 32'h1);
    // Nested elision, slot freed then reused
    ev(0, 32'h100);
    ckb("enter", res.enter, 1'b1);
    ev(0, 32'h140);
    rd(`TNAU_OFF_STATE, 32'h22);
    ev(1, 32'h140);
    ckb("commit", res.commit, 1'b0);
    ev(0, 32'h180);
    ckb("enter", res.enter, 1'b0);
    ev(1, 32'h180);
    ev(1, 32'h100);
    ckb("commit", res.commit, 1'b1);
    ckb("active", txn_active, 1'b0);
    rd(`TNAU_OFF_STATE, 32'h1);
    // Third lock overflows the tracker: keeps going, commit fails, replay
    ev(0, 32'h100);
    ev(0, 32'h140);
    ev(0, 32'h180);
    ckb("active", txn_active, 1'b1);
    ev(1, 32'h180);
    ev(1, 32'h140);
    ev(1, 32'h100);
    ckb("abort", res.abort, 1'b1);
    ckb("replay", res.replay_unhinted, 1'b1);
    rd(`TNAU_OFF_CTRL, 32'h1);
    wr(`TNAU_OFF_CTRL, 32'h0);
    for (i = 1; i <= 9; i++) begin
      ev(0, 32'h1000 + i * 64);
      ckb("enter", res.enter, i == 1);
      ckb("abort", res.abort, i == 9);
    end
    wr(`TNAU_OFF_CTRL, 32'h0);
    // Nested restricted abort goes back to the outermost fallback
    ev(2, 32'h2000);
    ev(2, 32'h3000);
    ev(4, 32'h5A);
    ckb("redirect", res.redirect, 1'b1);
    ckb("discard", res.discard, 1'b1);
    chk("target", res.target, 32'h2000);
    rd(`TNAU_OFF_STATUS, 32'h5A000021);
    ev(2, 32'h2000);
    ev(0, 32'h100);
    ckb("abort", res.abort, 1'b0);
    rd(`TNAU_OFF_STATE, 32'h104);
    ev(3, 32'h0);
    ckb("commit", res.commit, 1'b1);
    for (i = 1; i <= 8; i++) begin
      ev(2, 32'h2000);
      ckb("abort", res.abort, i == 8);
    end
    // Debug abort, default then advanced
    ev(2, 32'h2000);
    ev(5, 32'h0);
    ckb("redirect", res.redirect, 1'b1);
    rd(`TNAU_OFF_STATUS, 32'h10);
    @(posedge pclk);
    dcr <= 32'h800;
    msr <= 32'h8000;
    wr(`TNAU_OFF_STATUS, 32'h2);
    ev(2, 32'h2000);
    ev(5, 32'h0);
    ckb("restore", res.restore_begin, 1'b1);
    ckb("deliver", res.deliver_dbg, 1'b1);
    ckb("clear16", res.clr_dsr16, 1'b1);
    ckb("redirect", res.redirect, 1'b0);
    rd(`TNAU_OFF_STATUS, 32'h2);
    @(posedge pclk);
    dcr <= 32'h0;
    msr <= 32'h0;
    // Restricted op inside a hinted region, then plain cause bits
    ev(0, 32'h100);
    ev(2, 32'h2000);
    ckb("abort", res.abort, 1'b1);
    ckb("replay", res.replay_unhinted, 1'b1);
    wr(`TNAU_OFF_CTRL, 32'h0);
    for (i = 6; i <= 7; i++) begin
      ev(2, 32'h2000);
      ev(i, 32'h0);
      ckb("active", txn_active, 1'b0);
      rd(`TNAU_OFF_STATUS, (i == 6) ? 32'h4 : 32'h8);
    end
    final_report();
  end
endmodule
`default_nettype wire
